/* File: pmic_event_defs.svh */
/*
  Constants of the event flag and restore block: register offsets,
  reset values, field positions, bus address and timing figures.
  Assumes inclusion by bare name from design files of this block.
*/
`ifndef PMIC_EVENT_DEFS_SVH
`define PMIC_EVENT_DEFS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define CHARGER_EVENT_ENABLE_ADDR   8'h38
`define CHARGER_EVENT_FLAGS_ADDR    8'h39
`define REGULATOR_EVENT_ENABLE_ADDR 8'h3A
`define REGULATOR_EVENT_FLAGS_ADDR  8'h3B
`define FACTORY_RESTORE_ADDR        8'h3C
`define THERMISTOR_SELECT_ADDR      8'h3D

// -----------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------
`define CHARGER_ENABLE_RESET        8'h00
`define CHARGER_FLAGS_RESET         8'h00
`define REGULATOR_ENABLE_RESET      3'h0
`define REGULATOR_FLAGS_RESET       3'h0
`define THERMISTOR_SELECT_RESET     1'h1
`define RESTORE_CODE                8'h7F
`define READ_UNMAPPED               8'h00
`define DEVICE_ADDRESS              7'h44

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define WATCHDOG_ALARM_BIT          5
`define THERMISTOR_47K_BIT          0
`define REGULATOR_FLAG_BITS         3

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define CLOCK_HZ                    25000000
`define WATCHDOG_SHORT_PERIOD_S     7'h20
`define WATCHDOG_LONG_PERIOD_S      7'h40
`define WATCHDOG_SHORT_LEAD_S       7'h02
`define WATCHDOG_LONG_LEAD_S        7'h04

`endif

/* File: pmic_event_pkg.sv */
/*
  Types shared by the register port and the event flag logic.
  Assumes nothing of its surroundings.
*/
package pmic_event_pkg;

  // Register access carried from the serial port to the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_dev  = 5'b00010,
    st_ptr  = 5'b00100,
    st_wdat = 5'b01000,
    st_rdat = 5'b10000
  } port_state_e;

endpackage

/* File: serial_reg_port.sv */
/*
  Two-wire serial register port: device address match, register
  pointer with auto increment, byte writes and reads.
  Assumes scl and sda arrive asynchronously and that the register file
  answers a read request with read data on the next clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pmic_event_defs.svh"

module serial_reg_port (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Serial pins
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output var  logic                     sda_out,
  output var  logic                     sda_oe,
  // Register file side
  output var  pmic_event_pkg::reg_req_s req,
  input  wire logic [7:0]               rd_data
);
  import pmic_event_pkg::*;

  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_d;
  logic        sda_d;
  logic [7:0]  shreg;
  logic [3:0]  bitcnt;
  logic [7:0]  ptr;
  logic        rw;
  port_state_e state;
  logic        start_cond;
  logic        stop_cond;
  logic        scl_rise;
  logic        scl_fall;

  // -----------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'h1;
      sda_d    <= 1'h1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign scl_rise   = scl_sync[1] & ~scl_d;
  assign scl_fall   = ~scl_sync[1] & scl_d;

  // Open-drain: only ever pulls low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'h0;
    end else begin
      sda_out <= 1'h0;
    end
  end

  // -----------------------------------------------------------------
  // Transfer sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state  <= st_idle;
      shreg  <= 8'h00;
      bitcnt <= 4'h0;
      ptr    <= 8'h00;
      rw     <= 1'h0;
      sda_oe <= 1'h0;
      req    <= '0;
    end else begin
      req.wr <= 1'h0;
      req.rd <= 1'h0;
      if (start_cond) begin
        state  <= st_dev;
        bitcnt <= 4'h0;
        sda_oe <= 1'h0;
      end else if (stop_cond) begin
        state  <= st_idle;
        sda_oe <= 1'h0;
      end else begin
        case (state)
          st_dev, st_ptr, st_wdat: begin
            if (scl_rise && bitcnt < 4'h8) begin
              shreg  <= {shreg[6:0], sda_sync[1]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h9;
              if (state == st_dev && shreg[7:1] != `DEVICE_ADDRESS) begin
                state <= st_idle;
              end else begin
                sda_oe <= 1'h1;
                if (state == st_dev) begin
                  rw <= shreg[0];
                  if (shreg[0]) begin
                    req.rd   <= 1'h1;
                    req.addr <= ptr;
                    ptr      <= ptr + 8'h01;
                  end
                end else if (state == st_ptr) begin
                  ptr <= shreg;
                end else begin
                  req.wr    <= 1'h1;
                  req.addr  <= ptr;
                  req.wdata <= shreg;
                  ptr       <= ptr + 8'h01;
                end
              end
            end else if (scl_fall && bitcnt == 4'h9) begin
              bitcnt <= 4'h0;
              if (state == st_dev && rw) begin
                state  <= st_rdat;
                shreg  <= rd_data;
                sda_oe <= ~rd_data[7];
              end else begin
                state  <= (state == st_dev) ? st_ptr : st_wdat;
                sda_oe <= 1'h0;
              end
            end
          end
          st_rdat: begin
            if (scl_fall && bitcnt < 4'h7) begin
              bitcnt <= bitcnt + 4'h1;
              shreg  <= {shreg[6:0], 1'h0};
              sda_oe <= ~shreg[6];
            end else if (scl_fall && bitcnt == 4'h7) begin
              bitcnt <= 4'h8;
              sda_oe <= 1'h0;
            end else if (scl_rise && bitcnt == 4'h8) begin
              if (sda_sync[1]) begin
                state <= st_idle;
              end else begin
                bitcnt   <= 4'h9;
                req.rd   <= 1'h1;
                req.addr <= ptr;
                ptr      <= ptr + 8'h01;
              end
            end else if (scl_fall && bitcnt == 4'h9) begin
              bitcnt <= 4'h0;
              shreg  <= rd_data;
              sda_oe <= ~rd_data[7];
            end
          end
          default: begin
            sda_oe <= 1'h0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: pmic_event_flags_and_restore.sv */
/*
  Event flags, interrupt gating, factory restore and thermistor select
  of a battery management power device, with its serial register port.
  Assumes event sources are asynchronous levels from analog circuits;
  watchdog controls and the resistor option come from logic on clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pmic_event_defs.svh"

// Overview of operation
// - Charger flags: peak, isothermal, watchdog, thermal, etc.
// - Reading a flag register clears it
// - Watchdog alarm 2 s/4 s before expiry
// - Regulator enables gate three events onto pin
// - Regulator flags: LED open, boost, linreg1
// - Writing 0x7F restores all register defaults
// - Thermistor select: 47k when set and resistor option high, default 1
// - Charger enables gate each charger flag
module pmic_event_flags_and_restore #(
  parameter int unsigned TICKS_PER_SECOND = `CLOCK_HZ
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Serial register port pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  // Event sources
  input  wire logic [7:0] charger_event_src,
  input  wire logic [2:0] regulator_event_src,
  // Watchdog control
  input  wire logic       watchdog_enable,
  input  wire logic       watchdog_restart,
  input  wire logic       watchdog_period_setting,
  // Thermistor control
  input  wire logic       thermistor_resistor_option,
  output var  logic       thermistor_47k_active,
  // Interrupt pin
  output var  logic       irq_n
);
  import pmic_event_pkg::*;

  reg_req_s    req;
  logic [7:0]  rd_data;
  logic [7:0]  charger_event_enable;
  logic [7:0]  charger_event_flags;
  logic [2:0]  regulator_event_enable;
  logic [2:0]  regulator_event_flags;
  logic        thermistor_47k_select;
  logic [7:0]  chg_sync1;
  logic [7:0]  chg_sync2;
  logic [7:0]  chg_prev;
  logic [2:0]  reg_sync1;
  logic [2:0]  reg_sync2;
  logic [2:0]  reg_prev;
  logic [31:0] prescale;
  logic        second_tick;
  logic [6:0]  seconds;
  logic        alarm_pulse;
  logic [6:0]  alarm_point;
  logic        restore;
  logic        clr_charger;
  logic        clr_regulator;
  logic [7:0]  charger_set;
  logic [2:0]  regulator_set;

  // -----------------------------------------------------------------
  // Register port
  // -----------------------------------------------------------------
  serial_reg_port i_serial_reg_port (
    .clock   (clock),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .req     (req),
    .rd_data (rd_data)
  );

  assign restore       = req.wr && req.addr == `FACTORY_RESTORE_ADDR && req.wdata == `RESTORE_CODE;
  assign clr_charger   = req.rd && req.addr == `CHARGER_EVENT_FLAGS_ADDR;
  assign clr_regulator = req.rd && req.addr == `REGULATOR_EVENT_FLAGS_ADDR;

  // -----------------------------------------------------------------
  // Event source synchronisers and rising edge detection
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chg_sync1 <= 8'h00;
      chg_sync2 <= 8'h00;
      chg_prev  <= 8'h00;
      reg_sync1 <= 3'h0;
      reg_sync2 <= 3'h0;
      reg_prev  <= 3'h0;
    end else begin
      chg_sync1 <= charger_event_src;
      chg_sync2 <= chg_sync1;
      chg_prev  <= chg_sync2;
      reg_sync1 <= regulator_event_src;
      reg_sync2 <= reg_sync1;
      reg_prev  <= reg_sync2;
    end
  end

  // -----------------------------------------------------------------
  // Watchdog alarm timing
  // -----------------------------------------------------------------
  // One-second enable pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale    <= 32'h0000_0000;
      second_tick <= 1'h0;
    end else if (!watchdog_enable || watchdog_restart) begin
      prescale    <= 32'h0000_0000;
      second_tick <= 1'h0;
    end else if (prescale == TICKS_PER_SECOND - 1) begin
      prescale    <= 32'h0000_0000;
      second_tick <= 1'h1;
    end else begin
      prescale    <= prescale + 32'h0000_0001;
      second_tick <= 1'h0;
    end
  end

  assign alarm_point = watchdog_period_setting ?
                       (`WATCHDOG_LONG_PERIOD_S - `WATCHDOG_LONG_LEAD_S) :
                       (`WATCHDOG_SHORT_PERIOD_S - `WATCHDOG_SHORT_LEAD_S);

  // Elapsed seconds since restart; holds at 127 instead of wrapping
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seconds     <= 7'h00;
      alarm_pulse <= 1'h0;
    end else if (!watchdog_enable || watchdog_restart) begin
      seconds     <= 7'h00;
      alarm_pulse <= 1'h0;
    end else begin
      alarm_pulse <= 1'h0;
      if (second_tick && seconds != 7'h7F) begin
        seconds     <= seconds + 7'h01;
        alarm_pulse <= (seconds + 7'h01) == alarm_point;
      end
    end
  end

  // -----------------------------------------------------------------
  // Event flags: a new event wins over a clearing read
  // -----------------------------------------------------------------
  always_comb begin
    charger_set = chg_sync2 & ~chg_prev;
    charger_set[`WATCHDOG_ALARM_BIT] = charger_set[`WATCHDOG_ALARM_BIT] | alarm_pulse;
    regulator_set = reg_sync2 & ~reg_prev;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charger_event_flags <= `CHARGER_FLAGS_RESET;
    end else if (restore) begin
      charger_event_flags <= `CHARGER_FLAGS_RESET | charger_set;
    end else if (clr_charger) begin
      charger_event_flags <= charger_set;
    end else begin
      charger_event_flags <= charger_event_flags | charger_set;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regulator_event_flags <= `REGULATOR_FLAGS_RESET;
    end else if (restore) begin
      regulator_event_flags <= `REGULATOR_FLAGS_RESET | regulator_set;
    end else if (clr_regulator) begin
      regulator_event_flags <= regulator_set;
    end else begin
      regulator_event_flags <= regulator_event_flags | regulator_set;
    end
  end

  // -----------------------------------------------------------------
  // Writable registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charger_event_enable   <= `CHARGER_ENABLE_RESET;
      regulator_event_enable <= `REGULATOR_ENABLE_RESET;
      thermistor_47k_select  <= `THERMISTOR_SELECT_RESET;
    end else if (restore) begin
      charger_event_enable   <= `CHARGER_ENABLE_RESET;
      regulator_event_enable <= `REGULATOR_ENABLE_RESET;
      thermistor_47k_select  <= `THERMISTOR_SELECT_RESET;
    end else if (req.wr) begin
      case (req.addr)
        `CHARGER_EVENT_ENABLE_ADDR: begin
          charger_event_enable <= req.wdata;
        end
        `REGULATOR_EVENT_ENABLE_ADDR: begin
          regulator_event_enable <= req.wdata[`REGULATOR_FLAG_BITS-1:0];
        end
        `THERMISTOR_SELECT_ADDR: begin
          thermistor_47k_select <= req.wdata[`THERMISTOR_47K_BIT];
        end
        default: begin
          charger_event_enable <= charger_event_enable;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Read data, answered one edge after the request
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `READ_UNMAPPED;
    end else if (req.rd) begin
      case (req.addr)
        `CHARGER_EVENT_ENABLE_ADDR:   rd_data <= charger_event_enable;
        `CHARGER_EVENT_FLAGS_ADDR:    rd_data <= charger_event_flags;
        `REGULATOR_EVENT_ENABLE_ADDR: rd_data <= {5'h00, regulator_event_enable};
        `REGULATOR_EVENT_FLAGS_ADDR:  rd_data <= {5'h00, regulator_event_flags};
        `THERMISTOR_SELECT_ADDR:      rd_data <= {7'h00, thermistor_47k_select};
        default:                      rd_data <= `READ_UNMAPPED;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'h1;
    end else begin
      irq_n <= ~(|(charger_event_flags & charger_event_enable) |
                 |(regulator_event_flags & regulator_event_enable));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thermistor_47k_active <= 1'h0;
    end else begin
      thermistor_47k_active <= thermistor_resistor_option & thermistor_47k_select;
    end
  end

endmodule
`default_nettype wire

/* File: pmic_event_flags_and_restore_assertions.sv */
/*
  Port checker of the event flag block.
  Assumes it is bound into every instance of the block.
*/
`timescale 1ns/1ns
`default_nettype none
module pmic_event_checker #(
  parameter int unsigned TICKS_PER_SECOND = 10
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Serial pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Events and controls
  input wire logic [7:0] charger_event_src,
  input wire logic [2:0] regulator_event_src,
  input wire logic       watchdog_enable,
  input wire logic       watchdog_restart,
  input wire logic       watchdog_period_setting,
  input wire logic       thermistor_resistor_option,
  // Outputs
  input wire logic       thermistor_47k_active,
  input wire logic       irq_n
);
  logic [3:0] quiet_cnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Cycles with no event, watchdog or bus activity
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      quiet_cnt <= 4'h0;
    end else if (charger_event_src != 8'h00 || regulator_event_src != 3'h0 || watchdog_enable || !scl_in) begin
      quiet_cnt <= 4'h0;
    end else if (quiet_cnt != 4'hF) begin
      quiet_cnt <= quiet_cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_leaves_idle: assert property ($rose(rst_n) |-> irq_n && !sda_oe && !thermistor_47k_active)
    else $error("outputs not idle out of reset");
  a_therm_needs_option: assert property (thermistor_47k_active |-> $past(thermistor_resistor_option))
    else $error("47k select active without option");
  a_therm_default_on: assert property ($rose(rst_n) && thermistor_resistor_option |=> thermistor_47k_active)
    else $error("47k select not set out of reset");
  a_therm_change_cause: assert property ($changed(thermistor_47k_active) |-> !$past(rst_n, 2) || !$past(scl_in) || $past(thermistor_resistor_option) != $past(thermistor_resistor_option, 2))
    else $error("47k select changed without cause");
  a_irq_clear_access: assert property ($rose(irq_n) |-> !scl_in)
    else $error("interrupt released outside a bus byte");
  a_irq_no_cause: assert property (quiet_cnt >= 4'h8 |-> !$fell(irq_n))
    else $error("interrupt asserted with no event");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data driver changed while clock high");
  a_oe_sync_delay: assert property ($fell(scl_in) |-> !$rose(sda_oe) ##1 !$rose(sda_oe))
    else $error("data driver moved before clock synchronised");

  c_irq_low: cover property ($fell(irq_n));
  c_ack: cover property ($rose(sda_oe));
  c_therm: cover property ($rose(thermistor_47k_active));
endmodule

bind pmic_event_flags_and_restore pmic_event_checker #(.TICKS_PER_SECOND(TICKS_PER_SECOND)) i_pmic_event_checker (
  .clock, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .charger_event_src, .regulator_event_src,
  .watchdog_enable, .watchdog_restart, .watchdog_period_setting, .thermistor_resistor_option,
  .thermistor_47k_active, .irq_n
);
`default_nettype wire

/* File: host_i2c_model.sv */
/*
  Host processor model: two-wire bus master, open-drain data.
  Assumes the bench pulls the data wire up and feeds it back.
*/
`timescale 1ns/1ns
`default_nettype none
module host_i2c_model (
  // Clock
  input  wire logic clock,
  // Bus
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  logic [7:0] rd_byte;
  event       rd_ev;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Data moves mid low phase, sampled at end of high phase
  task automatic xbit(input logic b, output logic r);
    w(5);
    sda_low = ~b;
    w(5);
    scl = 1'b1;
    w(10);
    r = sda;
    scl = 1'b0;
  endtask

  // Start, also used as repeated start
  task automatic start();
    w(5);
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b1;
    w(10);
    scl = 1'b0;
  endtask

  task automatic stop();
    w(5);
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b0;
    w(10);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask

  // Single byte read, closed by a not-acknowledge
  task automatic rbyte();
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      rd_byte[i] = r;
    end
    xbit(1'b1, r);
    -> rd_ev;
  endtask
endmodule
`default_nettype wire

/* File: tb_pmic_event_flags_and_restore.sv */
/*
  Testbench of the event flag block: host model on the serial pins,
  events and watchdog controls from the bench.
  Assumes the block, its checker and the host model compile first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pmic_event_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module tb_pmic_event_flags_and_restore;
  logic        clock;
  logic        rst_n;
  logic        scl;
  logic        host_low;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic [7:0]  charger_event_src;
  logic [2:0]  regulator_event_src;
  logic        watchdog_enable;
  logic        watchdog_restart;
  logic        watchdog_period_setting;
  logic        thermistor_resistor_option;
  logic        thermistor_47k_active;
  logic        irq_n;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_byte;
  logic [7:0]  rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [31:0] seed = 32'h00012605;
  int          num_errors = 0;
  int          checked = 0;
  int          n;

  // Pulled-up data wire
  assign sda = !(host_low || (sda_oe && !sda_out));
  always #20 clock = ~clock;

  host_i2c_model i_host_i2c_model (.clock(clock), .scl(scl), .sda_low(host_low), .sda(sda));
  pmic_event_flags_and_restore #(.TICKS_PER_SECOND(10)) i_pmic_event_flags_and_restore (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .charger_event_src(charger_event_src), .regulator_event_src(regulator_event_src),
    .watchdog_enable(watchdog_enable), .watchdog_restart(watchdog_restart),
    .watchdog_period_setting(watchdog_period_setting), .thermistor_resistor_option(thermistor_resistor_option),
    .thermistor_47k_active(thermistor_47k_active), .irq_n(irq_n)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic conclude();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k1, k2, k3;
    i_host_i2c_model.start();
    i_host_i2c_model.wbyte({`DEVICE_ADDRESS, 1'b0}, k1);
    i_host_i2c_model.wbyte(a, k2);
    i_host_i2c_model.wbyte(d, k3);
    i_host_i2c_model.stop();
    `CHK({k1, k2, k3}, 3'b111)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic k1, k2, k3;
    exp_q.push_back(e);
    i_host_i2c_model.start();
    i_host_i2c_model.wbyte({`DEVICE_ADDRESS, 1'b0}, k1);
    i_host_i2c_model.wbyte(a, k2);
    i_host_i2c_model.start();
    i_host_i2c_model.wbyte({`DEVICE_ADDRESS, 1'b1}, k3);
    i_host_i2c_model.rbyte();
    i_host_i2c_model.stop();
    `CHK({k1, k2, k3}, 3'b111)
  endtask

  // Rising edges on the event sources, then time for flag and pin
  task automatic pulse(input logic [7:0] c, input logic [2:0] g);
    charger_event_src = c;
    regulator_event_src = g;
    repeat (2) @(negedge clock);
    charger_event_src = 8'h00;
    regulator_event_src = 3'h0;
    repeat (8) @(negedge clock);
  endtask

  initial begin
    forever begin
      @(i_host_i2c_model.rd_ev);
      exp_byte = exp_q.pop_front();
      `CHK(i_host_i2c_model.rd_byte, exp_byte)
    end
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    charger_event_src = 8'h00;
    regulator_event_src = 3'h0;
    watchdog_enable = 1'b0;
    watchdog_restart = 1'b0;
    watchdog_period_setting = 1'b0;
    thermistor_resistor_option = 1'b1;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(irq_n, 1'b1)
    `CHK(thermistor_47k_active, 1'b1)
    for (int i = 0; i < 6; i++) rd(8'h38 + 8'(i), rv[i]);
    rd(8'h50, `READ_UNMAPPED);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 3'h1 << (i % 3));
      rd(`CHARGER_EVENT_FLAGS_ADDR, 8'h01 << i);
      rd(`REGULATOR_EVENT_FLAGS_ADDR, 8'h01 << (i % 3));
      rd(`CHARGER_EVENT_FLAGS_ADDR, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      pulse(seed[7:0], seed[10:8]);
      rd(`CHARGER_EVENT_FLAGS_ADDR, seed[7:0]);
      rd(`REGULATOR_EVENT_FLAGS_ADDR, {5'h00, seed[10:8]});
      rd(`REGULATOR_EVENT_FLAGS_ADDR, 8'h00);
    end
    $display("flag tests done");
    wr(`CHARGER_EVENT_ENABLE_ADDR, 8'h20);
    wr(`REGULATOR_EVENT_ENABLE_ADDR, 8'h04);
    wr(`CHARGER_EVENT_FLAGS_ADDR, 8'hFF);
    rd(`CHARGER_EVENT_ENABLE_ADDR, 8'h20);
    rd(`REGULATOR_EVENT_ENABLE_ADDR, 8'h04);
    rd(`CHARGER_EVENT_FLAGS_ADDR, 8'h00);
    pulse(8'hDF, 3'h3);
    `CHK(irq_n, 1'b1)
    rd(`CHARGER_EVENT_FLAGS_ADDR, 8'hDF);
    rd(`REGULATOR_EVENT_FLAGS_ADDR, 8'h03);
    pulse(8'h20, 3'h0);
    `CHK(irq_n, 1'b0)
    rd(`CHARGER_EVENT_FLAGS_ADDR, 8'h20);
    `CHK(irq_n, 1'b1)
    pulse(8'h00, 3'h4);
    `CHK(irq_n, 1'b0)
    rd(`REGULATOR_EVENT_FLAGS_ADDR, 8'h04);
    `CHK(irq_n, 1'b1)
    $display("interrupt tests done");
    wr(`THERMISTOR_SELECT_ADDR, 8'h00);
    rd(`THERMISTOR_SELECT_ADDR, 8'h00);
    `CHK(thermistor_47k_active, 1'b0)
    wr(`THERMISTOR_SELECT_ADDR, 8'h01);
    thermistor_resistor_option = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(thermistor_47k_active, 1'b0)
    thermistor_resistor_option = 1'b1;
    wr(`THERMISTOR_SELECT_ADDR, 8'h00);
    wr(`FACTORY_RESTORE_ADDR, 8'h55);
    rd(`REGULATOR_EVENT_ENABLE_ADDR, 8'h04);
    pulse(8'h81, 3'h2);
    wr(`FACTORY_RESTORE_ADDR, `RESTORE_CODE);
    for (int i = 0; i < 6; i++) rd(8'h38 + 8'(i), rv[i]);
    `CHK(thermistor_47k_active, 1'b1)
    $display("restore tests done");
    wr(`CHARGER_EVENT_ENABLE_ADDR, 8'h20);
    for (int k = 0; k < 2; k++) begin
      watchdog_period_setting = 1'(k);
      watchdog_enable = 1'b1;
      repeat (100) @(negedge clock);
      watchdog_restart = 1'b1;
      @(negedge clock);
      watchdog_restart = 1'b0;
      n = 0;
      while (irq_n !== 1'b0 && n < 1000) begin
        @(negedge clock);
        n++;
      end
      if (n >= 1000) begin
        num_errors++;
        conclude();
      end
      `CHK((n + 5) / 10, k ? 64 - 4 : 32 - 2)
      watchdog_enable = 1'b0;
      rd(`CHARGER_EVENT_FLAGS_ADDR, 8'h20);
    end
    $display("watchdog tests done");
    conclude();
  end
endmodule
`default_nettype wire
